// [verilog/pao_pkg.sv]
package pao_pkg;
	localparam int unsigned RESULT_W     = 12;
	localparam int unsigned PART_W       = 4;
	localparam int unsigned NUM_STAGES   = 4;
	localparam int unsigned LATENCY_CYC  = 3;
	localparam int unsigned FIFO_DEPTH   = 8;
	localparam int unsigned MSB_IDX      = 11;
	localparam int unsigned LSB_IDX      = 0;
	// redundant overlap between stages: gain 8 with 4-bit codes leaves one bit
	localparam int unsigned STAGE_SHIFT  = 3;
	localparam logic [RESULT_W-1:0] CODE_MAX   = 12'hfff;
	localparam logic [RESULT_W-1:0] CODE_MIN   = 12'h000;
	localparam logic [RESULT_W-1:0] MID_LOW    = 12'h7ff;
	localparam logic [RESULT_W-1:0] MID_HIGH   = 12'h800;
	localparam logic [PART_W-1:0]   PART_BIAS  = 4'h4;
	typedef enum logic [0:0] {
		PH_SAMPLE,
		PH_HOLD
	} pao_phase_type;
endpackage

// [verilog/pao_fifo.sv]
`timescale 1ns/1ps
module pao_fifo #(
	parameter int unsigned WIDTH = 12,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             arst_n_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	wire              push;
	wire              pop;
	wire              wrap_wr;
	wire              wrap_rd;

	assign in_ready_o  = (count_reg != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid_o = (count_reg != '0);
	assign push        = in_valid_i && in_ready_o;
	assign pop         = out_valid_o && out_ready_i;
	assign wrap_wr     = (wr_ptr_reg == AW'(DEPTH - 1));
	assign wrap_rd     = (rd_ptr_reg == AW'(DEPTH - 1));
	assign out_data_o  = mem_reg[rd_ptr_reg];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wrap_wr ? '0 : wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= wrap_rd ? '0 : rd_ptr_reg + AW'(1);
			end
			if (push && !pop) begin
				count_reg <= count_reg + (AW+1)'(1);
			end else if (pop && !push) begin
				count_reg <= count_reg - (AW+1)'(1);
			end
		end
	end
endmodule // pao_fifo

// [verilog/pao_top.sv]
`timescale 1ns/1ps
// Contract
// - the result of a sample appears on the output bus on the third clock after sampling; here a word shows six clocks after its stage 0 code is given.
// - after the latency one new result follows on every clock.
// - the corrected word is held in an output latch that changes with the external clock.
// - output words are offset binary, lowest code for most negative input.
// - two non-overlapping internal phases, sampling and holding, come from the master clock.
// - the sample is captured as the sampling phase ends and is held in the holding phase; here stage codes are taken on every clk_i rising edge.
// - three identical 4-bit stages are followed by a final 4-bit-only stage.
// - each stage's 4-bit code runs through a delay line so one sample's codes align.
// - error correction merges the aligned codes and redundant bits into a 12-bit word.
// - each stage is clocked in antiphase to the previous one; here every stage and delay flop is clocked on the rising edge of clk_i.
// - bit 11 of the result is the msb and bit 0 the lsb.
// - positive full scale gives all ones, negative full scale all zeros, mid-scale 7ff/800.
module pao_top (
	input  wire logic                         clk_i,
	input  wire logic                         arst_n_i,
	input  wire logic [pao_pkg::PART_W-1:0]   stage_code_i [pao_pkg::NUM_STAGES],
	output logic                              sample_phase_o,
	output logic                              hold_phase_o,
	output logic      [pao_pkg::RESULT_W-1:0] result_o,
	output logic                              result_msb_o,
	output logic                              result_lsb_o,
	output logic                              result_valid_o,
	input  wire logic                         result_ready_i
);
	// stage codes arrive from flash comparators outside this clock: two flops each
	logic [pao_pkg::PART_W-1:0] meta_reg [pao_pkg::NUM_STAGES];
	logic [pao_pkg::PART_W-1:0] code_reg [pao_pkg::NUM_STAGES];
	// delay line: stage k waits NUM_STAGES-1-k full-clock hops
	logic [pao_pkg::PART_W-1:0] dly_reg [pao_pkg::NUM_STAGES][pao_pkg::NUM_STAGES];
	pao_pkg::pao_phase_type     phase_reg;
	logic [pao_pkg::RESULT_W-1:0] latch_reg;
	logic [1:0]                 fill_reg;
	logic                       primed;
	logic [pao_pkg::RESULT_W+2:0] corr_sum;
	logic [pao_pkg::RESULT_W-1:0] corr_word;
	logic                       fifo_in_ready;
	logic                       fifo_out_valid;
	logic [pao_pkg::RESULT_W-1:0] fifo_out_data;

	// phase alternates per clock; outputs are mutually exclusive so never overlap
	assign sample_phase_o = (phase_reg == pao_pkg::PH_SAMPLE);
	assign hold_phase_o   = (phase_reg == pao_pkg::PH_HOLD);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			phase_reg <= pao_pkg::PH_SAMPLE;
		end else begin
			phase_reg <= (phase_reg == pao_pkg::PH_SAMPLE) ? pao_pkg::PH_HOLD
				: pao_pkg::PH_SAMPLE;
		end
	end

	genvar s;
	genvar d;
	generate
		for (s = 0; s < pao_pkg::NUM_STAGES; s++) begin : g_stage
			always_ff @(posedge clk_i or negedge arst_n_i) begin
				if (!arst_n_i) begin
					meta_reg[s] <= '0;
					code_reg[s] <= '0;
				end else begin
					meta_reg[s] <= stage_code_i[s];
					code_reg[s] <= meta_reg[s];
				end
			end
			assign dly_reg[s][0] = code_reg[s];
			// each hop is one internal clock; stage s enters later, so needs fewer hops
			for (d = 1; d < pao_pkg::NUM_STAGES; d++) begin : g_tap
				always_ff @(posedge clk_i or negedge arst_n_i) begin
					if (!arst_n_i) begin
						dly_reg[s][d] <= '0;
					end else begin
						dly_reg[s][d] <= dly_reg[s][d-1];
					end
				end
			end
		end
	endgenerate

	// overlap-add: each stage weighted by 2^(3*(3-k)), redundant bit absorbs comparator error;
	// stages 1 to 3 carry a bias of 4 that is removed here
	always_comb begin
		corr_sum = '0;
		for (int k = 0; k < pao_pkg::NUM_STAGES; k++) begin
			corr_sum = corr_sum + ((pao_pkg::RESULT_W+3)'(
				dly_reg[k][pao_pkg::NUM_STAGES-1-k]) << (pao_pkg::STAGE_SHIFT
				* (pao_pkg::NUM_STAGES - 1 - k)));
			if (k != 0) begin
				corr_sum = corr_sum - ((pao_pkg::RESULT_W+3)'(pao_pkg::PART_BIAS)
					<< (pao_pkg::STAGE_SHIFT * (pao_pkg::NUM_STAGES - 1 - k)));
			end
		end
	end

	// clamp to offset-binary range: overrange pins at all ones or all zeros
	assign corr_word = corr_sum[pao_pkg::RESULT_W+2] ? pao_pkg::CODE_MIN
		: (|corr_sum[pao_pkg::RESULT_W+1:pao_pkg::RESULT_W]) ? pao_pkg::CODE_MAX
		: corr_sum[pao_pkg::RESULT_W-1:0];

	// output latch on the external clock, one new word per clock
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			latch_reg <= pao_pkg::CODE_MIN;
			fill_reg  <= '0;
		end else begin
			latch_reg <= corr_word;
			if (!primed) begin
				fill_reg <= fill_reg + 2'h1;
			end
		end
	end

	// the first three words after start are not marked valid, though the next three still carry reset stage codes
	assign primed = (fill_reg == 2'(pao_pkg::LATENCY_CYC));

	assign result_o     = latch_reg;
	assign result_msb_o = latch_reg[pao_pkg::MSB_IDX];
	assign result_lsb_o = latch_reg[pao_pkg::LSB_IDX];

	// side copy for a stallable consumer; the pin bus never stalls, so full drops words
	pao_fifo #(
		.WIDTH(pao_pkg::RESULT_W),
		.DEPTH(pao_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i      (clk_i),
		.arst_n_i   (arst_n_i),
		.in_valid_i (primed),
		.in_ready_o (fifo_in_ready),
		.in_data_i  (latch_reg),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(result_ready_i),
		.out_data_o (fifo_out_data)
	);

	// a full copy buffer only drops new words; what it holds stays on offer
	assign result_valid_o = fifo_out_valid;
endmodule // pao_top

// [tb/pao_top_asserts.sv]
`timescale 1ns/1ps
module pao_top_asserts (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic [3:0]  stage_code_i [4],
	input  wire logic        sample_phase_o,
	input  wire logic        hold_phase_o,
	input  wire logic [11:0] result_o,
	input  wire logic        result_msb_o,
	input  wire logic        result_lsb_o,
	input  wire logic        result_valid_o,
	input  wire logic        result_ready_i
);
	logic [3:0]  age_reg;
	// bias 4 on stages 1..3 removed as one constant
	function automatic logic [11:0] merge_codes(logic [3:0] a, logic [3:0] b, logic [3:0] c,
		logic [3:0] d);
		int s;
		s = int'(a) * 512 + int'(b) * 64 + int'(c) * 8 + int'(d) - 292;
		return (s < 0) ? 12'h000 : (s > 4095) ? 12'hfff : s[11:0];
	endfunction
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) age_reg <= 4'h0;
		else if (age_reg != 4'hf) age_reg <= age_reg + 4'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_phase_split: assert property (sample_phase_o != hold_phase_o)
		else $error("phases overlap");
	a_phase_swap: assert property (sample_phase_o |=> hold_phase_o)
		else $error("hold phase missing");
	a_phase_back: assert property (hold_phase_o |=> sample_phase_o)
		else $error("sample phase missing");
	a_msb_map: assert property (result_msb_o == result_o[11])
		else $error("msb pin wrong");
	a_lsb_map: assert property (result_lsb_o == result_o[0])
		else $error("lsb pin wrong");
	// later stages resolve one clock after the stage before them
	a_word_latency: assert property (age_reg > 4'h7 |-> result_o == merge_codes(
		$past(stage_code_i[0], 6), $past(stage_code_i[1], 5),
		$past(stage_code_i[2], 4), $past(stage_code_i[3], 3)))
		else $error("result word wrong");
	a_valid_early: assert property (age_reg < 4'h4 |-> !result_valid_o)
		else $error("unprimed word offered");
	a_valid_hold: assert property (result_valid_o && !result_ready_i |=> result_valid_o)
		else $error("word lost under stall");
endmodule // pao_top_asserts
bind pao_top pao_top_asserts u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i),
	.stage_code_i(stage_code_i), .sample_phase_o(sample_phase_o),
	.hold_phase_o(hold_phase_o), .result_o(result_o), .result_msb_o(result_msb_o),
	.result_lsb_o(result_lsb_o), .result_valid_o(result_valid_o),
	.result_ready_i(result_ready_i));

// [tb/pao_capture.sv]
`timescale 1ns/1ps
module pao_capture (
	input  wire logic        clk_i,
	input  wire logic        arst_n_i,
	input  wire logic        valid_i,
	input  wire logic [11:0] data_i,
	input  wire logic        stall_i,
	output logic             ready_o,
	output int               taken_o
);
	logic [11:0] last_reg;
	// a stalled capture simply refuses; it asks for words again as soon as stall_i falls
	assign ready_o = !stall_i;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) taken_o <= 0;
		else if (valid_i && ready_o) taken_o <= taken_o + 1;
	end
	always_ff @(posedge clk_i) begin
		if (valid_i && ready_o) last_reg <= data_i;
	end
endmodule // pao_capture

// [tb/tb_pipelined_adc_output_path.sv]
`timescale 1ns/1ps
module tb_pipelined_adc_output_path;
	logic        clk_i = 1'b0;
	logic        arst_n_i = 1'b0;
	logic [3:0]  stage_code_i [4];
	logic        stall = 1'b0;
	logic        ready, phs, phh, msb, lsb, valid;
	logic [11:0] result;
	logic [15:0] hist [$];
	int          err_total = 0;
	int          samples_checked = 0;
	int          seed = 81446;
	int          taken;
	int          held;
	always #5 clk_i = ~clk_i;
	pao_top u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .stage_code_i(stage_code_i),
		.sample_phase_o(phs), .hold_phase_o(phh), .result_o(result), .result_msb_o(msb),
		.result_lsb_o(lsb), .result_valid_o(valid), .result_ready_i(ready));
	pao_capture u_cap (.clk_i(clk_i), .arst_n_i(arst_n_i), .valid_i(valid), .data_i(result),
		.stall_i(stall), .ready_o(ready), .taken_o(taken));
	function automatic logic [11:0] expect_word(logic [3:0] a, b, c, d);
		int s;
		s = a * 512 + b * 64 + c * 8 + d - 292;
		return (s < 0) ? 12'h000 : (s > 4095) ? 12'hfff : s[11:0];
	endfunction
	task automatic check_word(logic [11:0] got, logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// stage k of the word seen now was given 6-k falling edges ago
	task automatic step(logic [3:0] a, b, c, d, logic s);
		@(negedge clk_i);
		stage_code_i = '{a, b, c, d};
		stall = s;
		hist.push_back({a, b, c, d});
		if (hist.size() > 6) begin
			check_word(result, expect_word(hist[0][15:12], hist[1][11:8], hist[2][7:4],
				hist[3][3:0]));
			void'(hist.pop_front());
		end
	endtask
	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		stage_code_i = '{4'h0, 4'h0, 4'h0, 4'h0};
		repeat (4) @(negedge clk_i);
		arst_n_i = 1'b1;
		// floor, 7ff, 800, top, then both overranges
		// each held four clocks so all stages of one word agree
		repeat (4) step(4'h0, 4'h4, 4'h4, 4'h4, 1'b0);
		repeat (4) step(4'h3, 4'hb, 4'hb, 4'hb, 1'b0);
		repeat (4) step(4'h4, 4'h4, 4'h4, 4'h4, 1'b0);
		repeat (4) step(4'h7, 4'hb, 4'hb, 4'hb, 1'b0);
		repeat (4) step(4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
		repeat (4) step(4'hf, 4'hf, 4'hf, 4'hf, 1'b0);
		repeat (300) step($random(seed), $random(seed), $random(seed), $random(seed),
			$random(seed));
		$display("test stream done");
		step($random(seed), 4'h4, 4'h4, $random(seed), 1'b1);
		held = taken;
		repeat (11) step($random(seed), 4'h4, 4'h4, $random(seed), 1'b1);
		check_word({11'h0, valid}, 12'h001);
		check_word(12'(taken - held), 12'h000);
		$display("test stall done");
		@(negedge clk_i);
		arst_n_i = 1'b0;
		hist.delete();
		#1;
		check_word(result, 12'h000);
		check_word({11'h0, valid}, 12'h000);
		@(negedge clk_i);
		arst_n_i = 1'b1;
		repeat (40) step($random(seed), $random(seed), $random(seed), $random(seed),
			1'b0);
		$display("test reset done");
		print_verdict();
	end
endmodule // tb_pipelined_adc_output_path
